/* File: logic/ddspr_pkg.sv */
// shared types and constants for the profile, ramp and keying control block
package ddspr_pkg;
    localparam int FTW_W = 32;
    localparam int POW_W = 16;
    localparam int ASF_W = 14;
    localparam int PROF_N = 8;
    localparam int PROF_W = 3;
    localparam int RAMP_W = 32;
    localparam int RATE_W = 16;
    localparam int PHASE_ACC_CLEAR_BIT = 11;
    localparam int AMP_SHIFT = ASF_W;
    localparam logic [ASF_W-1:0] ASF_FULL = 14'h3fff;
    localparam logic [FTW_W-1:0] FTW_RESET = 32'h0000_0000;
    localparam logic [RAMP_W-1:0] RAMP_RESET = 32'h0000_0000;
    localparam logic [RATE_W-1:0] RATE_RESET = 16'h0000;

    typedef enum logic [1:0] {
        DDSPR_DEST_FREQ,
        DDSPR_DEST_PHASE,
        DDSPR_DEST_AMP
    } ddspr_dest_e;

    typedef enum logic [1:0] {
        DDSPR_RAMP_IDLE,
        DDSPR_RAMP_UP,
        DDSPR_RAMP_DOWN
    } ddspr_ramp_e;

    typedef struct packed {
        logic [FTW_W-1:0] ftw;
        logic [POW_W-1:0] pow;
        logic [ASF_W-1:0] amplitude_scale_factor;
    } ddspr_profile_s;

    typedef struct packed {
        logic matched_latency;
        logic auto_clr_phase;
        logic [15:0] cfr_low;
        logic sync_clk_en;
        logic profile_asf_en;
        logic sine_sel;
        logic ram_en;
        logic int_update_en;
        logic [RATE_W-1:0] int_update_rate;
    } ddspr_cfg_s;

    typedef struct packed {
        logic en;
        ddspr_dest_e dest;
        logic auto_clr;
        logic clr;
        logic rate_reload;
        logic no_dwell_hi;
        logic no_dwell_lo;
        logic [RAMP_W-1:0] lower;
        logic [RAMP_W-1:0] upper;
        logic [RAMP_W-1:0] step_up;
        logic [RAMP_W-1:0] step_dn;
        logic [RATE_W-1:0] rate_up;
        logic [RATE_W-1:0] rate_dn;
    } ddspr_ramp_s;

    typedef struct packed {
        logic en;
        logic auto_mode;
        logic rate_reload;
        logic [RATE_W-1:0] rate;
        logic [ASF_W-1:0] step;
    } ddspr_osk_s;

    typedef struct packed {
        logic [FTW_W-1:0] ftw;
        logic [POW_W-1:0] pow;
    } ddspr_aux_s;
endpackage

/* File: logic/ddspr_rate_timer.sv */
// interval timer that pulses once every period + 1 cycles while running and can be reloaded
`timescale 1ns/100ps
`default_nettype none
module ddspr_rate_timer
    import ddspr_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reload,
    input wire logic run,
    input wire logic [RATE_W-1:0] period,
    output logic tick
);
    logic [RATE_W-1:0] count_reg;
    logic [RATE_W-1:0] count_next;
    wire expired = (count_reg == RATE_RESET);
    wire [RATE_W-1:0] count_dec = count_reg - 16'h0001;

    assign count_next = (reload || expired) ? period : (run ? count_dec : count_reg);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count_reg <= RATE_RESET;
            tick <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick <= run && expired && !reload;
        end
    end
endmodule
`default_nettype wire

/* File: logic/ddspr_core.sv */
// profile, ramp generator and output shift keying control of the synthesizer core
`timescale 1ns/100ps
`default_nettype none
module ddspr_core
    import ddspr_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic buf_wr,
    input wire ddspr_cfg_s buf_cfg,
    input wire ddspr_ramp_s buf_ramp,
    input wire ddspr_osk_s buf_osk,
    input wire ddspr_aux_s buf_aux,
    input wire logic [PROF_W-1:0] buf_prof_idx,
    input wire ddspr_profile_s buf_prof,
    input wire logic io_update_in,
    input wire logic [PROF_W-1:0] profile_pins,
    input wire logic ramp_up_ctl,
    input wire logic ramp_hold,
    input wire logic output_shift_keying_pin,
    input wire logic ram_sweep_done,
    input wire logic sync_clk_in,
    output logic io_update_out,
    output logic io_update_oe,
    output logic sync_clk_out,
    output logic sync_clk_oe,
    output logic [FTW_W-1:0] ftw_out,
    output logic [POW_W-1:0] phase_out,
    output logic [ASF_W-1:0] amp_out,
    output logic sine_out_sel,
    output logic ram_sweep_over_flag,
    output logic ramp_finished
);
    // holding buffer, written by the host side
    ddspr_cfg_s hold_cfg_reg;
    ddspr_ramp_s hold_ramp_reg;
    ddspr_osk_s hold_osk_reg;
    ddspr_aux_s hold_aux_reg;
    ddspr_profile_s hold_prof_reg [PROF_N];
    // active copies
    ddspr_cfg_s cfg_reg;
    ddspr_ramp_s ramp_reg;
    ddspr_osk_s osk_reg;
    ddspr_aux_s aux_reg;
    ddspr_profile_s prof_reg [PROF_N];

    logic upd_in_d_reg;
    logic [PROF_W-1:0] prof_idx_reg;
    logic [RATE_W-1:0] int_cnt_reg;
    logic [FTW_W-1:0] phase_acc_reg;
    logic [RAMP_W-1:0] ramp_acc_reg;
    ddspr_ramp_e ramp_state_reg;
    logic [ASF_W-1:0] osk_amp_reg;
    logic [FTW_W-1:0] ftw_stage_reg;
    logic [POW_W-1:0] pow_stage_reg;

    // update sources
    wire int_fire = cfg_reg.int_update_en && (int_cnt_reg == RATE_RESET);
    wire ext_rise = io_update_in && !upd_in_d_reg && !cfg_reg.int_update_en;
    wire io_update = ext_rise || int_fire;
    wire profile_change = (profile_pins != prof_idx_reg);
    wire upd_or_prof = io_update || profile_change;

    ddspr_profile_s act_prof;
    assign act_prof = prof_reg[prof_idx_reg];

    // phase accumulator clear
    wire phase_clr = cfg_reg.cfr_low[PHASE_ACC_CLEAR_BIT]
        || (cfg_reg.auto_clr_phase && upd_or_prof);

    // ramp generator
    wire ramp_clr = ramp_reg.clr
        || (ramp_reg.auto_clr && upd_or_prof);
    wire ramp_reload = ramp_reg.rate_reload && upd_or_prof;
    wire ramp_run = ramp_reg.en && !ramp_hold && !ramp_clr;
    wire going_up = ramp_up_ctl;
    logic tick_up;
    logic tick_dn;
    logic tick_amp;

    ddspr_rate_timer u_up_timer (
        .core_clk(core_clk),
        .reset(reset),
        .reload(ramp_reload),
        .run(ramp_run && going_up),
        .period(ramp_reg.rate_up),
        .tick(tick_up)
    );

    ddspr_rate_timer u_dn_timer (
        .core_clk(core_clk),
        .reset(reset),
        .reload(ramp_reload),
        .run(ramp_run && !going_up),
        .period(ramp_reg.rate_dn),
        .tick(tick_dn)
    );

    wire [RAMP_W:0] sum_up = {1'b0, ramp_acc_reg} + {1'b0, ramp_reg.step_up};
    wire [RAMP_W:0] diff_dn = {1'b0, ramp_acc_reg} - {1'b0, ramp_reg.step_dn};
    wire hit_top = sum_up[RAMP_W] || (sum_up[RAMP_W-1:0] >= ramp_reg.upper);
    wire hit_bot = diff_dn[RAMP_W] || (diff_dn[RAMP_W-1:0] <= ramp_reg.lower);
    wire at_top = (ramp_acc_reg == ramp_reg.upper);
    wire at_bot = (ramp_acc_reg == ramp_reg.lower);

    logic [RAMP_W-1:0] ramp_acc_next;
    ddspr_ramp_e ramp_state_next;
    always_comb begin
        ramp_acc_next = ramp_acc_reg;
        ramp_state_next = ramp_state_reg;
        if (ramp_clr || !ramp_reg.en) begin
            ramp_acc_next = RAMP_RESET;
            ramp_state_next = DDSPR_RAMP_IDLE;
        end else if (ramp_run) begin
            if (ramp_state_reg == DDSPR_RAMP_IDLE && ramp_acc_reg < ramp_reg.lower) begin
                ramp_acc_next = ramp_reg.lower;
            end
            if (going_up && tick_up) begin
                ramp_state_next = DDSPR_RAMP_UP;
                ramp_acc_next = hit_top ? ramp_reg.upper : sum_up[RAMP_W-1:0];
            end else if (!going_up && tick_dn) begin
                ramp_state_next = DDSPR_RAMP_DOWN;
                ramp_acc_next = hit_bot ? ramp_reg.lower : diff_dn[RAMP_W-1:0];
            end
            // no-dwell: jump back to the opposite limit on reaching one
            if (going_up && at_top && ramp_reg.no_dwell_hi) begin
                ramp_acc_next = ramp_reg.lower;
            end
            if (!going_up && at_bot && ramp_reg.no_dwell_lo) begin
                ramp_acc_next = ramp_reg.upper;
            end
        end
    end

    wire ramp_done = ramp_reg.en && (going_up ? at_top : at_bot);

    // output shift keying
    wire osk_reload = osk_reg.rate_reload && upd_or_prof;
    wire [ASF_W-1:0] asf_sel = cfg_reg.profile_asf_en ? act_prof.amplitude_scale_factor : ASF_FULL;
    wire [ASF_W-1:0] osk_target = output_shift_keying_pin ? asf_sel : '0;

    ddspr_rate_timer u_amp_timer (
        .core_clk(core_clk),
        .reset(reset),
        .reload(osk_reload),
        .run(osk_reg.en && osk_reg.auto_mode),
        .period(osk_reg.rate),
        .tick(tick_amp)
    );

    wire [ASF_W:0] amp_up = {1'b0, osk_amp_reg} + {1'b0, osk_reg.step};
    wire [ASF_W:0] amp_dn = {1'b0, osk_amp_reg} - {1'b0, osk_reg.step};
    logic [ASF_W-1:0] osk_amp_next;
    always_comb begin
        osk_amp_next = osk_amp_reg;
        if (!osk_reg.en) begin
            osk_amp_next = asf_sel;
        end else if (!osk_reg.auto_mode) begin
            osk_amp_next = osk_target;
        end else if (tick_amp) begin
            if (osk_amp_reg < osk_target) begin
                osk_amp_next = (amp_up[ASF_W] || amp_up[ASF_W-1:0] > osk_target)
                    ? osk_target : amp_up[ASF_W-1:0];
            end else if (osk_amp_reg > osk_target) begin
                osk_amp_next = (amp_dn[ASF_W] || amp_dn[ASF_W-1:0] < osk_target)
                    ? osk_target : amp_dn[ASF_W-1:0];
            end
        end
    end

    // source selection for the three words
    wire [FTW_W-1:0] base_ftw = cfg_reg.ram_en ? aux_reg.ftw : act_prof.ftw;
    wire [POW_W-1:0] base_pow = cfg_reg.ram_en ? aux_reg.pow : act_prof.pow;
    wire dest_f = ramp_reg.en && ramp_reg.dest == DDSPR_DEST_FREQ;
    wire dest_p = ramp_reg.en && ramp_reg.dest == DDSPR_DEST_PHASE;
    wire dest_a = ramp_reg.en && ramp_reg.dest == DDSPR_DEST_AMP;
    wire [FTW_W-1:0] sel_ftw = dest_f ? ramp_acc_reg : base_ftw;
    wire [POW_W-1:0] sel_pow = dest_p ? ramp_acc_reg[RAMP_W-1 -: POW_W] : base_pow;
    wire [ASF_W-1:0] sel_amp = dest_a ? ramp_acc_reg[RAMP_W-1 -: ASF_W] : osk_amp_reg;
    // phase offset adds onto the top 16 bits: one lsb is a 1/65536 turn
    wire [POW_W-1:0] phase_word = phase_acc_reg[FTW_W-1 -: POW_W] + sel_pow;
    wire [FTW_W-1:0] phase_acc_sum = phase_acc_reg + ftw_stage_reg;

    // holding buffer writes
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            hold_cfg_reg <= '0;
            hold_ramp_reg <= '0;
            hold_osk_reg <= '0;
            hold_aux_reg <= '0;
        end else if (buf_wr) begin
            hold_cfg_reg <= buf_cfg;
            hold_ramp_reg <= buf_ramp;
            hold_osk_reg <= buf_osk;
            hold_aux_reg <= buf_aux;
        end
    end

    for (genvar i = 0; i < PROF_N; i++) begin : g_prof
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                hold_prof_reg[i] <= '0;
                prof_reg[i] <= '0;
            end else begin
                if (buf_wr && buf_prof_idx == PROF_W'(i)) begin
                    hold_prof_reg[i] <= buf_prof;
                end
                if (io_update) begin
                    prof_reg[i] <= hold_prof_reg[i];
                end
            end
        end
    end

    // transfer to active on update
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cfg_reg <= '0;
            ramp_reg <= '0;
            osk_reg <= '0;
            aux_reg <= '0;
        end else if (io_update) begin
            cfg_reg <= hold_cfg_reg;
            ramp_reg <= hold_ramp_reg;
            osk_reg <= hold_osk_reg;
            aux_reg <= hold_aux_reg;
        end
    end

    // update timing, profile tracking and internal update pulse
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            upd_in_d_reg <= 1'b0;
            prof_idx_reg <= '0;
            int_cnt_reg <= RATE_RESET;
            io_update_out <= 1'b0;
            io_update_oe <= 1'b0;
        end else begin
            upd_in_d_reg <= io_update_in;
            prof_idx_reg <= profile_pins;
            int_cnt_reg <= (int_fire || !cfg_reg.int_update_en)
                ? cfg_reg.int_update_rate : int_cnt_reg - 16'h0001;
            io_update_out <= int_fire;
            io_update_oe <= cfg_reg.int_update_en;
        end
    end

    // accumulators and staging of the words
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            phase_acc_reg <= FTW_RESET;
            ramp_acc_reg <= RAMP_RESET;
            ramp_state_reg <= DDSPR_RAMP_IDLE;
            osk_amp_reg <= '0;
            ftw_stage_reg <= FTW_RESET;
            pow_stage_reg <= '0;
        end else begin
            phase_acc_reg <= phase_clr ? FTW_RESET : phase_acc_sum;
            ramp_acc_reg <= ramp_acc_next;
            ramp_state_reg <= ramp_state_next;
            osk_amp_reg <= osk_amp_next;
            ftw_stage_reg <= sel_ftw;
            pow_stage_reg <= sel_pow;
        end
    end

    // output stage; the phase path is one stage shorter in both settings, and matched latency bypasses the amplitude ramp
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ftw_out <= FTW_RESET;
            phase_out <= '0;
            amp_out <= '0;
            sine_out_sel <= 1'b0;
            ram_sweep_over_flag <= 1'b0;
            ramp_finished <= 1'b0;
            sync_clk_out <= 1'b0;
            sync_clk_oe <= 1'b0;
        end else begin
            ftw_out <= ftw_stage_reg;
            phase_out <= phase_word;
            amp_out <= cfg_reg.matched_latency ? osk_amp_reg : sel_amp;
            sine_out_sel <= cfg_reg.sine_sel;
            // set wins over the clear coming from a fresh update
            ram_sweep_over_flag <= (cfg_reg.ram_en && ram_sweep_done)
                || (ram_sweep_over_flag && !io_update);
            ramp_finished <= ramp_done;
            sync_clk_out <= sync_clk_in && cfg_reg.sync_clk_en;
            sync_clk_oe <= cfg_reg.sync_clk_en;
        end
    end
endmodule
`default_nettype wire

/* File: verification/ddspr_core_monitor.sv */
// assertion checker bound to the profile, ramp and keying control core
`timescale 1ns/100ps
`default_nettype none
module ddspr_core_monitor
    import ddspr_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic io_update_in,
    input wire logic ram_sweep_done,
    input wire logic sync_clk_in,
    input wire logic io_update_out,
    input wire logic io_update_oe,
    input wire logic sync_clk_out,
    input wire logic sync_clk_oe,
    input wire logic [FTW_W-1:0] ftw_out,
    input wire logic [POW_W-1:0] phase_out,
    input wire logic [ASF_W-1:0] amp_out,
    input wire logic sine_out_sel,
    input wire logic ram_sweep_over_flag
);
    logic [3:0] upd_hist_reg;
    logic recent;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // an update in the last few cycles excuses a change of active settings
    assign recent = (|upd_hist_reg) | io_update_oe;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            upd_hist_reg <= 4'h0;
        end else begin
            upd_hist_reg <= {upd_hist_reg[2:0], io_update_in | io_update_out};
        end
    end
    AST_SYNC_GATE: assert property ($stable(sync_clk_oe)
        |-> sync_clk_out == (sync_clk_oe & $past(sync_clk_in))) else $error("sync gate");
    AST_UPD_OE: assert property (io_update_out |-> io_update_oe)
        else $error("update pulse without enable");
    AST_UPD_PULSE: assert property (io_update_out |=> !io_update_out)
        else $error("update pulse too long");
    AST_FLAG_SET: assert property ($rose(ram_sweep_over_flag) |-> $past(ram_sweep_done))
        else $error("sweep flag without cause");
    AST_FLAG_HOLD: assert property (ram_sweep_over_flag && !io_update_oe && !recent
        && !io_update_in |=> ram_sweep_over_flag) else $error("sweep flag lost");
    AST_SINE_UPD: assert property ($changed(sine_out_sel) |-> recent)
        else $error("sine select changed without update");
    AST_SYNC_OE_UPD: assert property ($changed(sync_clk_oe) |-> recent)
        else $error("sync enable changed without update");
    AST_OE_UPD: assert property ($changed(io_update_oe) |-> |upd_hist_reg)
        else $error("update enable changed without update");
    AST_RESET_ZERO: assert property ($past(reset) |-> ftw_out == 32'h0
        && amp_out == 14'h0 && phase_out == 16'h0 && !sine_out_sel) else $error("not zero");
endmodule

bind ddspr_core ddspr_core_monitor u_mon (
    .core_clk(core_clk),
    .reset(reset),
    .io_update_in(io_update_in),
    .ram_sweep_done(ram_sweep_done),
    .sync_clk_in(sync_clk_in),
    .io_update_out(io_update_out),
    .io_update_oe(io_update_oe),
    .sync_clk_out(sync_clk_out),
    .sync_clk_oe(sync_clk_oe),
    .ftw_out(ftw_out),
    .phase_out(phase_out),
    .amp_out(amp_out),
    .sine_out_sel(sine_out_sel),
    .ram_sweep_over_flag(ram_sweep_over_flag)
);
`default_nettype wire

/* File: verification/ddspr_host_model.sv */
// host model driving update, profile, ramp control and keying pins
`timescale 1ns/100ps
`default_nettype none
module ddspr_host_model
    import ddspr_pkg::*;
(
    input wire logic core_clk,
    output logic io_update_in,
    output logic [PROF_W-1:0] profile_pins,
    output logic ramp_up_ctl,
    output logic ramp_hold,
    output logic output_shift_keying_pin
);
    initial begin
        io_update_in = 1'b0;
        profile_pins = 3'h0;
        ramp_up_ctl = 1'b0;
        ramp_hold = 1'b0;
        output_shift_keying_pin = 1'b0;
    end
    // low cycle after the pulse so the next rising edge is seen
    task automatic update();
        @(negedge core_clk);
        io_update_in = 1'b1;
        @(negedge core_clk);
        io_update_in = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic set_pins(input logic [2:0] p, input logic up, input logic hold,
                            input logic key);
        @(negedge core_clk);
        profile_pins = p;
        ramp_up_ctl = up;
        ramp_hold = hold;
        output_shift_keying_pin = key;
    endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the profile, ramp and keying control core
`timescale 1ns/100ps
`default_nettype none
module testbench
    import ddspr_pkg::*;
();
    logic core_clk, reset, buf_wr, sync_clk_in, ram_sweep_done;
    logic io_update_in, ramp_up_ctl, ramp_hold, key_pin;
    logic upd_out, upd_oe, sync_out, sync_oe, sine_sel, sweep_flag, fin;
    logic [PROF_W-1:0] widx, pins;
    logic [FTW_W-1:0] ftw;
    logic [POW_W-1:0] ph;
    logic [ASF_W-1:0] amp;
    ddspr_cfg_s cfg;
    ddspr_ramp_s rmp;
    ddspr_osk_s output_shift_keying;
    ddspr_aux_s aux;
    ddspr_profile_s pr [PROF_N];
    int errors, compares, n;

    ddspr_host_model u_host (.core_clk(core_clk), .io_update_in(io_update_in),
        .profile_pins(pins), .ramp_up_ctl(ramp_up_ctl), .ramp_hold(ramp_hold),
        .output_shift_keying_pin(key_pin));
    ddspr_core u_dut (.core_clk(core_clk), .reset(reset), .buf_wr(buf_wr),
        .buf_cfg(cfg), .buf_ramp(rmp), .buf_osk(output_shift_keying), .buf_aux(aux),
        .buf_prof_idx(widx), .buf_prof(pr[widx]), .io_update_in(io_update_in),
        .profile_pins(pins), .ramp_up_ctl(ramp_up_ctl), .ramp_hold(ramp_hold),
        .output_shift_keying_pin(key_pin), .ram_sweep_done(ram_sweep_done),
        .sync_clk_in(sync_clk_in), .io_update_out(upd_out), .io_update_oe(upd_oe),
        .sync_clk_out(sync_out), .sync_clk_oe(sync_oe), .ftw_out(ftw), .phase_out(ph),
        .amp_out(amp), .sine_out_sel(sine_sel), .ram_sweep_over_flag(sweep_flag),
        .ramp_finished(fin));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(negedge core_clk) sync_clk_in <= ~sync_clk_in;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge core_clk);
    endtask
    task automatic wr(input int i);
        @(negedge core_clk);
        widx = 3'(i);
        buf_wr = 1'b1;
        @(negedge core_clk);
        buf_wr = 1'b0;
    endtask
    task automatic apply();
        wr(0);
        u_host.update();
        cyc(6);
    endtask
    task automatic wait_ftw();
        logic [31:0] v;
        v = ftw;
        n = 0;
        while (ftw === v && n < 20) begin
            @(negedge core_clk);
            n++;
        end
    endtask
    task automatic wait_pulse();
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (upd_out !== 1'b1 && n < 20);
    endtask
    task automatic end_of_test();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic t_buffer();
        cfg.sine_sel = 1'b1;
        cfg.sync_clk_en = 1'b1;
        wr(0);
        cyc(5);
        chk(sine_sel, 0);
        chk(sync_oe, 0);
        u_host.update();
        cyc(4);
        chk(sine_sel, 1);
        chk(sync_oe, 1);
        cfg.sine_sel = 1'b0;
        apply();
        chk(sine_sel, 0);
    endtask
    task automatic t_prof();
        for (int i = 1; i < PROF_N; i++) begin
            wr(i);
        end
        // hold the phase accumulator at zero so phase_out shows the offset alone
        cfg.cfr_low[PHASE_ACC_CLEAR_BIT] = 1'b1;
        cfg.profile_asf_en = 1'b1;
        cfg.matched_latency = 1'b1;
        apply();
        for (int i = 0; i < PROF_N; i++) begin
            u_host.set_pins(3'(i ^ 5), 1'b0, 1'b0, 1'b0);
            cyc(6);
            chk(ftw, pr[i ^ 5].ftw);
            chk(ph, pr[i ^ 5].pow);
            chk(amp, pr[i ^ 5].amplitude_scale_factor);
        end
        cfg.profile_asf_en = 1'b0;
        apply();
        chk(amp, ASF_FULL);
    endtask
    task automatic t_ram();
        aux = {32'hcafe_0001, 16'h0abc};
        cfg.ram_en = 1'b1;
        apply();
        chk(ftw, aux.ftw);
        chk(ph, aux.pow);
        ram_sweep_done = 1'b1;
        cyc(1);
        ram_sweep_done = 1'b0;
        cyc(2);
        chk(sweep_flag, 1);
        u_host.update();
        cyc(3);
        chk(sweep_flag, 0);
        cfg.ram_en = 1'b0;
        apply();
    endtask
    task automatic t_ramp();
        rmp.en = 1'b1;
        rmp.dest = DDSPR_DEST_FREQ;
        rmp.lower = 32'h0000_0100;
        rmp.upper = 32'h0000_0140;
        rmp.step_up = 32'h0000_0010;
        rmp.step_dn = 32'h0000_0020;
        rmp.rate_up = 16'h0001;
        rmp.rate_dn = 16'h0002;
        u_host.set_pins(3'h0, 1'b1, 1'b0, 1'b0);
        apply();
        cyc(60);
        chk(ftw, rmp.upper);
        chk(fin, 1);
        u_host.set_pins(3'h0, 1'b0, 1'b0, 1'b0);
        cyc(20);
        chk(ftw, rmp.lower);
        chk(fin, 1);
        u_host.set_pins(3'h0, 1'b1, 1'b1, 1'b0);
        cyc(10);
        chk(ftw, rmp.lower);
        u_host.set_pins(3'h0, 1'b1, 1'b0, 1'b0);
        wait_ftw();
        chk(ftw, rmp.lower + rmp.step_up);
        wait_ftw();
        chk(32'(n), 2);
        rmp.clr = 1'b1;
        apply();
        chk(ftw, 0);
        cyc(8);
        chk(ftw, 0);
        rmp.clr = 1'b0;
        apply();
        chk(32'(ftw != 32'h0), 1);
        rmp.en = 1'b0;
        apply();
    endtask
    task automatic t_osk();
        cfg.profile_asf_en = 1'b1;
        output_shift_keying.en = 1'b1;
        u_host.set_pins(3'h3, 1'b0, 1'b0, 1'b0);
        apply();
        chk(amp, 0);
        u_host.set_pins(3'h3, 1'b0, 1'b0, 1'b1);
        cyc(3);
        chk(amp, pr[3].amplitude_scale_factor);
        u_host.set_pins(3'h3, 1'b0, 1'b0, 1'b0);
        cyc(3);
        chk(amp, 0);
        output_shift_keying.auto_mode = 1'b1;
        output_shift_keying.step = 14'h0400;
        output_shift_keying.rate = 16'h0001;
        apply();
        u_host.set_pins(3'h3, 1'b0, 1'b0, 1'b1);
        cyc(40);
        chk(amp, pr[3].amplitude_scale_factor);
        u_host.set_pins(3'h3, 1'b0, 1'b0, 1'b0);
        cyc(40);
        chk(amp, 0);
        output_shift_keying.en = 1'b0;
        apply();
    endtask
    task automatic t_int();
        cfg.int_update_en = 1'b1;
        cfg.int_update_rate = 16'h0003;
        apply();
        chk(upd_oe, 1);
        wait_pulse();
        wait_pulse();
        chk(32'(n), 4);
        cfg.int_update_en = 1'b0;
        wr(0);
        cyc(12);
        chk(upd_oe, 0);
    endtask

    initial begin
        reset = 1'b1;
        buf_wr = 1'b0;
        sync_clk_in = 1'b0;
        ram_sweep_done = 1'b0;
        widx = 3'h0;
        cfg = '0;
        rmp = '0;
        output_shift_keying = '0;
        aux = '0;
        for (int i = 0; i < PROF_N; i++) begin
            pr[i] = {32'h1000_0000 + 32'(i), 16'h1111 * 16'(i), 14'h0400 * 14'(i + 1)};
        end
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        cyc(1);
        chk(ftw, 0);
        chk(sync_oe, 0);
        chk(upd_oe, 0);
        t_buffer();
        t_prof();
        t_ram();
        t_ramp();
        t_osk();
        t_int();
        end_of_test();
    end
    initial begin
        #100000;
        errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
